//--- design/fach_device.sv
// module: device end, decodes requests and runs geometry and erase commands
// ------------------------------------------------------------
// Summary of operation
// - requests go to cluster 0x23, endpoint 0xE6
// - header: cmd, options, block, offset, length
// - multi-byte fields sent most significant first
// - unicast request gets reply to source endpoint
// - broadcast requests get no reply
// - reply shown as explicit receive frame
// - reply byte 1 carries status, not options
// - status bit 0 flags error, rest reserved
// - geometry query: code 0x00, zero fields
// - geometry reply 0x80, block count, size
// - geometry and erase reply length zero
// - flash is 119 blocks of 512 bytes
// - erase uses code 0x01, block index given
// - erase sets every bit to one
// - erase whole blocks only, offset ignored
// - length zero erases every block
// - single erase length equals block size
// - erase reply 0x81 echoes block, offset
// ------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module fach_device
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // link
  fach_link_if.device link,
  // status
  output logic        busy,
  output logic        erasing
);
  import fach_pkg::*;

  typedef enum logic [2:0] {FACH_S_RECV, FACH_S_DRAIN, FACH_S_EXEC, FACH_S_ERASE,
                            FACH_S_SEND} fach_dstate_t;

  fach_dstate_t state_q;
  logic [2:0]   idx_q;
  logic [7:0]   hdr_q [FACH_HDR_BYTES];
  logic [7:0]   src_ep_q;
  logic         reply_q;
  logic [7:0]   status_q;
  logic [7:0]   rcmd_q;
  logic [15:0]  rblk_q;
  logic [15:0]  rofs_q;
  logic [15:0]  ers_addr_q;
  logic [15:0]  ers_end_q;
  logic         rsp_valid_q;
  logic         rsp_first_q;
  logic [7:0]   rsp_byte_q;
  logic         req_ready_q;
  logic         accept_q;

  // ------------------------------------------------------------
  // decode of captured header
  // ------------------------------------------------------------
  wire [7:0]  cmd_w   = hdr_q[FACH_POS_CMD];
  wire [15:0] blk_w   = {hdr_q[FACH_POS_BLK], hdr_q[FACH_POS_BLK+1]};
  wire [15:0] ofs_w   = {hdr_q[FACH_POS_OFS], hdr_q[FACH_POS_OFS+1]};
  wire [15:0] len_w   = {hdr_q[FACH_POS_LEN], hdr_q[FACH_POS_LEN+1]};
  wire        is_geom = (cmd_w == FACH_CMD_GEOM_Q);
  wire        is_ers  = (cmd_w == FACH_CMD_ERASE);
  wire        ers_all = is_ers && (len_w == 16'h0000);
  wire        blk_ok  = (blk_w < FACH_NUM_BLOCKS16);
  wire        bad     = !(is_geom || is_ers) || (is_ers && !ers_all && !blk_ok);
  wire [15:0] blk_base = 16'(blk_w * FACH_BLOCK_BYTES16);
  wire        for_us  = (link.req_cluster == FACH_CLUSTER_ID)
                     && (link.req_dst_ep == FACH_ENDPOINT);
  wire        take    = link.req_valid && req_ready_q;
  wire        last_hdr = take && (idx_q == 3'(FACH_HDR_BYTES-1));
  wire        ers_last = (ers_addr_q == ers_end_q);

  // response byte mux, multi-byte fields most significant first
  logic [7:0] out_byte;
  always_comb
  begin
    out_byte = 8'h00;
    case (idx_q)
      3'd0:    out_byte = rcmd_q;
      3'd1:    out_byte = status_q;
      3'd2:    out_byte = rblk_q[15:8];
      3'd3:    out_byte = rblk_q[7:0];
      3'd4:    out_byte = rofs_q[15:8];
      3'd5:    out_byte = rofs_q[7:0];
      default: out_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // flash array
  // ------------------------------------------------------------
  fach_flash u_flash
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (state_q == FACH_S_ERASE),
    .addr    (ers_addr_q),
    .wr_data (FACH_ERASED_BYTE),
    .rd_data ()
  );

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= FACH_S_RECV;
      idx_q       <= 3'd0;
      src_ep_q    <= 8'h00;
      reply_q     <= 1'b0;
      accept_q    <= 1'b0;
      status_q    <= FACH_STATUS_OK;
      rcmd_q      <= 8'h00;
      rblk_q      <= 16'h0000;
      rofs_q      <= 16'h0000;
      ers_addr_q  <= 16'h0000;
      ers_end_q   <= 16'h0000;
      rsp_valid_q <= 1'b0;
      rsp_first_q <= 1'b0;
      rsp_byte_q  <= 8'h00;
      req_ready_q <= 1'b1;
      busy        <= 1'b0;
      erasing     <= 1'b0;
      for (int i = 0; i < FACH_HDR_BYTES; i++)
        hdr_q[i] <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      rsp_first_q <= 1'b0;
      case (state_q)
        FACH_S_RECV:
        begin
          if (take)
          begin
            if (link.req_first)
            begin
              hdr_q[0] <= link.req_byte;
              idx_q    <= 3'd1;
              src_ep_q <= link.req_src_ep;
              reply_q  <= !link.req_bcast && for_us;
              accept_q <= for_us;
            end
            else
            begin
              hdr_q[idx_q] <= link.req_byte;
              idx_q        <= idx_q + 3'd1;
            end
            if (last_hdr && !link.req_first)
            begin
              state_q     <= FACH_S_EXEC;
              req_ready_q <= 1'b0;
              busy        <= 1'b1;
            end
          end
        end
        FACH_S_EXEC:
        begin
          rcmd_q   <= cmd_w | FACH_CMD_RESP_BIT;
          status_q <= bad ? FACH_STATUS_ERR : FACH_STATUS_OK;
          rblk_q   <= is_geom ? FACH_NUM_BLOCKS16 : blk_w;
          rofs_q   <= is_geom ? FACH_BLOCK_BYTES16 : ofs_w;
          idx_q    <= 3'd0;
          // broadcast erase still runs, only the reply is suppressed
          if (is_ers && !bad && accept_q)
          begin
            ers_addr_q <= ers_all ? 16'h0000 : blk_base;
            ers_end_q  <= ers_all ? 16'(FACH_MEM_BYTES-1)
                                  : 16'(blk_base + FACH_BLOCK_BYTES16 - 16'h0001);
            erasing    <= 1'b1;
            state_q    <= FACH_S_ERASE;
          end
          else
            state_q <= reply_q ? FACH_S_SEND : FACH_S_DRAIN;
        end
        FACH_S_ERASE:
        begin
          ers_addr_q <= ers_addr_q + 16'h0001;
          if (ers_last)
          begin
            erasing <= 1'b0;
            state_q <= reply_q ? FACH_S_SEND : FACH_S_DRAIN;
          end
        end
        FACH_S_SEND:
        begin
          rsp_valid_q <= 1'b1;
          rsp_first_q <= (idx_q == 3'd0);
          rsp_byte_q  <= out_byte;
          idx_q       <= idx_q + 3'd1;
          if (idx_q == 3'(FACH_HDR_BYTES-1))
            state_q <= FACH_S_DRAIN;
        end
        FACH_S_DRAIN:
        begin
          idx_q       <= 3'd0;
          req_ready_q <= 1'b1;
          busy        <= 1'b0;
          state_q     <= FACH_S_RECV;
        end
        default: state_q <= FACH_S_RECV;
      endcase
    end
  end

  assign link.req_ready  = req_ready_q;
  assign link.rsp_valid  = rsp_valid_q;
  assign link.rsp_first  = rsp_first_q;
  assign link.rsp_byte   = rsp_byte_q;
  assign link.rsp_dst_ep = src_ep_q;
endmodule // fach_device
`default_nettype wire

//--- design/fach_flash.sv
// module: flash storage array with one byte read/write port; the device erases by writing through it byte by byte
`timescale 1ns/10ps
`default_nettype none
module fach_flash
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // access port
  input  wire logic                         wr_en,
  input  wire logic [fach_pkg::FACH_ADDR_W-1:0] addr,
  input  wire logic [7:0]                   wr_data,
  output logic      [7:0]                   rd_data
);
  import fach_pkg::*;

  logic [7:0] mem [FACH_MEM_BYTES];

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[addr] <= wr_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 8'h00;
    else
      rd_data <= mem[addr];
  end
endmodule // fach_flash
`default_nettype wire

//--- design/fach_host.sv
// module: requester end, sends register-built requests and gathers replies
`timescale 1ns/10ps
`default_nettype none
module fach_host
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  // link
  fach_link_if.host        link
);
  import fach_pkg::*;

  typedef enum logic [1:0] {FACH_H_IDLE, FACH_H_SEND, FACH_H_WAIT} fach_hstate_t;

  fach_hstate_t state_q;
  logic [31:0] hdr0_q;
  logic [31:0] hdr1_q;
  logic [31:0] resp0_q;
  logic [31:0] resp1_q;
  logic [7:0]  src_ep_q;
  logic        bcast_q;
  logic [2:0]  idx_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_mask_q;
  logic        rsp_ep_q;
  logic        req_valid_q;
  logic        req_first_q;
  logic [7:0]  req_byte_q;

  wire [63:0] req_hdr = {hdr0_q, hdr1_q};
  wire        start   = wr && (addr == FACH_REG_CTRL) && wdata[0] && (state_q == FACH_H_IDLE);
  wire        sent    = link.req_valid && link.req_ready;
  wire        got_rsp = link.rsp_valid && (state_q == FACH_H_WAIT);
  wire        rsp_end = got_rsp && (idx_q == 3'(FACH_HDR_BYTES-1));
  wire [63:0] rsp_hdr = {resp0_q, resp1_q};
  wire [63:0] rsp_nxt = {rsp_hdr[55:0], link.rsp_byte};
  wire        clr_w   = wr && (addr == FACH_REG_IRQ);
  wire [1:0]  ev      = {rsp_end && rsp_nxt[FACH_HDR_BYTES*8-9-7], rsp_end};

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (addr)
      FACH_REG_CTRL:   rd_mux = {15'h0000, bcast_q, src_ep_q, 6'h00, rsp_ep_q,
                                 state_q != FACH_H_IDLE};
      FACH_REG_HDR0:   rd_mux = hdr0_q;
      FACH_REG_HDR1:   rd_mux = hdr1_q;
      FACH_REG_RESP0:  rd_mux = resp0_q;
      FACH_REG_RESP1:  rd_mux = resp1_q;
      FACH_REG_STATUS: rd_mux = {24'h000000, resp0_q[23:16]};
      FACH_REG_IRQ:    rd_mux = {30'h0, irq_st_q};
      FACH_REG_MASK:   rd_mux = {30'h0, irq_mask_q};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // registers and sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= FACH_H_IDLE;
      hdr0_q      <= 32'h0000_0000;
      hdr1_q      <= 32'h0000_0000;
      resp0_q     <= 32'h0000_0000;
      resp1_q     <= 32'h0000_0000;
      src_ep_q    <= FACH_SRC_EP_RST;
      bcast_q     <= 1'b0;
      idx_q       <= 3'd0;
      irq_st_q    <= 2'b00;
      irq_mask_q  <= 2'b00;
      rsp_ep_q    <= 1'b0;
      req_valid_q <= 1'b0;
      req_first_q <= 1'b0;
      req_byte_q  <= 8'h00;
      rdata       <= 32'h0000_0000;
      irq         <= 1'b0;
    end
    else
    begin
      rdata    <= rd ? rd_mux : 32'h0000_0000;
      irq_st_q <= ev | (irq_st_q & ~(clr_w ? wdata[1:0] : 2'b00));   // set wins
      irq      <= |(irq_st_q & irq_mask_q);
      if (wr && addr == FACH_REG_HDR0 && state_q == FACH_H_IDLE)
        hdr0_q <= wdata;
      if (wr && addr == FACH_REG_HDR1 && state_q == FACH_H_IDLE)
        hdr1_q <= wdata;
      if (wr && addr == FACH_REG_MASK)
        irq_mask_q <= wdata[1:0];
      if (wr && addr == FACH_REG_CTRL && state_q == FACH_H_IDLE)
      begin
        src_ep_q <= wdata[15:8];
        bcast_q  <= wdata[16];
      end
      case (state_q)
        FACH_H_IDLE:
        begin
          if (start)
          begin
            idx_q       <= 3'd0;
            req_valid_q <= 1'b1;
            req_first_q <= 1'b1;
            req_byte_q  <= req_hdr[63:56];
            state_q     <= FACH_H_SEND;
          end
        end
        FACH_H_SEND:
        begin
          if (sent)
          begin
            req_first_q <= 1'b0;
            idx_q       <= idx_q + 3'd1;
            req_byte_q  <= req_hdr[6'(55 - 8*int'(idx_q)) -: 8];
            if (idx_q == 3'(FACH_HDR_BYTES-1))
            begin
              req_valid_q <= 1'b0;
              idx_q       <= 3'd0;
              state_q     <= bcast_q ? FACH_H_IDLE : FACH_H_WAIT;
            end
          end
        end
        FACH_H_WAIT:
        begin
          if (got_rsp)
          begin
            {resp0_q, resp1_q} <= rsp_nxt;
            idx_q              <= idx_q + 3'd1;
            if (rsp_end)
            begin
              rsp_ep_q <= (src_ep_q == FACH_ENDPOINT);
              state_q  <= FACH_H_IDLE;
            end
          end
        end
        default: state_q <= FACH_H_IDLE;
      endcase
    end
  end

  assign link.req_valid   = req_valid_q;
  assign link.req_first   = req_first_q;
  assign link.req_byte    = req_byte_q;
  assign link.req_src_ep  = src_ep_q;
  assign link.req_dst_ep  = FACH_ENDPOINT;
  assign link.req_cluster = FACH_CLUSTER_ID;
  assign link.req_bcast   = bcast_q;
endmodule // fach_host
`default_nettype wire

//--- inc/fach_link_if.sv
// interface: byte-serial request and response channel between the two ends
`timescale 1ns/10ps
`default_nettype none
interface fach_link_if;
  logic       req_valid;
  logic       req_first;
  logic [7:0] req_byte;
  logic [7:0] req_src_ep;
  logic [7:0] req_dst_ep;
  logic [15:0] req_cluster;
  logic       req_bcast;
  logic       req_ready;
  logic       rsp_valid;
  logic       rsp_first;
  logic [7:0] rsp_byte;
  logic [7:0] rsp_dst_ep;

  modport device
  (
    input  req_valid, req_first, req_byte, req_src_ep, req_dst_ep, req_cluster, req_bcast,
    output req_ready, rsp_valid, rsp_first, rsp_byte, rsp_dst_ep
  );
  modport host
  (
    output req_valid, req_first, req_byte, req_src_ep, req_dst_ep, req_cluster, req_bcast,
    input  req_ready, rsp_valid, rsp_first, rsp_byte, rsp_dst_ep
  );
endinterface : fach_link_if
`default_nettype wire

//--- inc/fach_pkg.sv
// package: constants shared by the flash-area command handler ends
package fach_pkg;
  // ------------------------------------------------------------
  // addressing
  // ------------------------------------------------------------
  localparam logic [15:0] FACH_CLUSTER_ID  = 16'h0023;
  localparam logic [7:0]  FACH_ENDPOINT    = 8'hE6;
  // ------------------------------------------------------------
  // payload byte positions
  // ------------------------------------------------------------
  localparam int FACH_POS_CMD    = 0;
  localparam int FACH_POS_OPT    = 1;
  localparam int FACH_POS_BLK    = 2;
  localparam int FACH_POS_OFS    = 4;
  localparam int FACH_POS_LEN    = 6;
  localparam int FACH_HDR_BYTES  = 8;
  // ------------------------------------------------------------
  // command codes
  // ------------------------------------------------------------
  localparam logic [7:0] FACH_CMD_GEOM_Q   = 8'h00;
  localparam logic [7:0] FACH_CMD_ERASE    = 8'h01;
  localparam logic [7:0] FACH_CMD_GEOM_R   = 8'h80;
  localparam logic [7:0] FACH_CMD_ERASE_R  = 8'h81;
  localparam logic [7:0] FACH_CMD_RESP_BIT = 8'h80;
  localparam logic [7:0] FACH_STATUS_OK    = 8'h00;
  localparam logic [7:0] FACH_STATUS_ERR   = 8'h01;
  // ------------------------------------------------------------
  // flash geometry
  // ------------------------------------------------------------
  localparam int              FACH_NUM_BLOCKS  = 119;
  localparam int              FACH_BLOCK_BYTES = 512;
  localparam logic [15:0]     FACH_NUM_BLOCKS16  = 16'h0077;
  localparam logic [15:0]     FACH_BLOCK_BYTES16 = 16'h0200;
  localparam logic [7:0]      FACH_ERASED_BYTE   = 8'hFF;
  localparam int              FACH_ADDR_W = 16;
  localparam int              FACH_MEM_BYTES = FACH_NUM_BLOCKS * FACH_BLOCK_BYTES;
  // ------------------------------------------------------------
  // host register map (word index)
  // ------------------------------------------------------------
  localparam logic [3:0] FACH_REG_CTRL   = 4'h0;
  localparam logic [3:0] FACH_REG_HDR0   = 4'h1;
  localparam logic [3:0] FACH_REG_HDR1   = 4'h2;
  localparam logic [3:0] FACH_REG_RESP0  = 4'h3;
  localparam logic [3:0] FACH_REG_RESP1  = 4'h4;
  localparam logic [3:0] FACH_REG_STATUS = 4'h5;
  localparam logic [3:0] FACH_REG_IRQ    = 4'h6;
  localparam logic [3:0] FACH_REG_MASK   = 4'h7;
  localparam logic [7:0] FACH_SRC_EP_RST = 8'hE6;
  localparam int         FACH_IRQ_DONE   = 0;
  localparam int         FACH_IRQ_ERR    = 1;
endpackage : fach_pkg

//--- tb/fach_link_checker.sv
// checker: link handshake and reply content assertions for both ends
`timescale 1ns/10ps
`default_nettype none
module fach_link_checker
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // request side
  input wire logic       req_valid,
  input wire logic       req_first,
  input wire logic [7:0] req_byte,
  input wire logic [7:0] req_src_ep,
  input wire logic       req_bcast,
  input wire logic       req_ready,
  // reply side
  input wire logic       rsp_valid,
  input wire logic       rsp_first,
  input wire logic [7:0] rsp_byte,
  input wire logic [7:0] rsp_dst_ep
);
  import fach_pkg::*;
  // ------------------------------------------------------------
  // request capture and byte indices
  // ------------------------------------------------------------
  logic [2:0]  ri_q;
  logic [2:0]  si_q;
  logic        bc_q;
  logic [7:0]  ep_q;
  logic [7:0]  rq_q [8];
  wire         take = req_valid & req_ready;
  wire  [2:0]  ri   = req_first ? 3'h0 : ri_q;
  wire  [2:0]  si   = rsp_first ? 3'h0 : si_q;
  wire  [15:0] blk  = {rq_q[2], rq_q[3]};
  wire         all  = ({rq_q[6], rq_q[7]} == 16'h0000);
  wire         bad  = (rq_q[0] > FACH_CMD_ERASE) ||
                      (rq_q[0] == FACH_CMD_ERASE && !all && blk >= FACH_NUM_BLOCKS16);
  wire  [7:0]  geom = (si == 3'h3) ? 8'h77 : (si == 3'h4) ? 8'h02 : 8'h00;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ri_q <= 3'h0;
      si_q <= 3'h0;
      bc_q <= 1'b0;
      ep_q <= 8'h00;
    end
    else
    begin
      if (take)
        ri_q <= ri + 3'h1;
      if (take && req_first)
        bc_q <= req_bcast;
      if (take && req_first)
        ep_q <= req_src_ep;
      if (rsp_valid)
        si_q <= si + 3'h1;
    end
  always_ff @(posedge clk)
    if (take)
      rq_q[ri] <= req_byte;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_last_hdr;
    take && ri == 3'h7;
  endsequence
  sequence s_ready_low;
    ##[1:2] !req_ready;
  endsequence
  property p_hdr_stop;
    s_last_hdr |-> s_ready_low;
  endproperty
  a_hdr_stop: assert property (p_hdr_stop)
    else $error("ready held after eight header bytes");
  property p_ready_back;
    rsp_valid && si == 3'h7 |-> ##[1:20] req_ready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready not restored after reply");
  property p_no_bcast;
    rsp_valid |-> !bc_q;
  endproperty
  a_no_bcast: assert property (p_no_bcast)
    else $error("reply to broadcast request");
  property p_dst_ep;
    rsp_valid |-> rsp_dst_ep == ep_q;
  endproperty
  a_dst_ep: assert property (p_dst_ep)
    else $error("reply endpoint differs from request source");
  property p_code;
    rsp_valid && si == 3'h0 |-> rsp_byte == (rq_q[0] | FACH_CMD_RESP_BIT) && rsp_first;
  endproperty
  a_code: assert property (p_code)
    else $error("wrong reply code");
  property p_status;
    rsp_valid && si == 3'h1 |-> rsp_byte == {7'h00, bad};
  endproperty
  a_status: assert property (p_status)
    else $error("status byte wrong");
  property p_len_zero;
    rsp_valid && si >= 3'h6 |-> rsp_byte == 8'h00;
  endproperty
  a_len_zero: assert property (p_len_zero)
    else $error("reply length not zero");
  property p_geom;
    rsp_valid && rq_q[0] == FACH_CMD_GEOM_Q && si inside {[2:5]} |-> rsp_byte == geom;
  endproperty
  a_geom: assert property (p_geom)
    else $error("geometry field wrong");
  property p_echo;
    rsp_valid && rq_q[0] == FACH_CMD_ERASE && si inside {[2:5]} |-> rsp_byte == rq_q[si];
  endproperty
  a_echo: assert property (p_echo)
    else $error("erase reply does not echo request");
endmodule // fach_link_checker
`default_nettype wire

//--- tb/tb_flash_area_command_handler.sv
// testbench: host and device ends joined over the link, run through registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, what) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %0t %s got %h exp %h", $time, what, got, exp); end end
module tb_flash_area_command_handler;
  import fach_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_p = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        busy;
  logic        erasing;
  logic [7:0]  e_b;
  logic [31:0] e_w;
  logic [31:0] e_m;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc_n = 0;
  logic [7:0]  rsp_q [$];
  logic [31:0] rd_q [$];
  logic [31:0] rm_q [$];
  fach_link_if link ();
  fach_host fach_host_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .link(link));
  fach_device fach_device_i (.clk(clk), .rst_n(rst_n), .link(link), .busy(busy),
    .erasing(erasing));
  fach_link_checker fach_link_checker_i (.clk(clk), .rst_n(rst_n),
    .req_valid(link.req_valid), .req_first(link.req_first), .req_byte(link.req_byte),
    .req_src_ep(link.req_src_ep), .req_bcast(link.req_bcast), .req_ready(link.req_ready),
    .rsp_valid(link.rsp_valid), .rsp_first(link.rsp_first), .rsp_byte(link.rsp_byte),
    .rsp_dst_ep(link.rsp_dst_ep));
  always #50 clk = ~clk;
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge clk);
    rd_q.push_back(d);
    rm_q.push_back(m);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
  endtask
  // one request: header, start twice (second ignored), wait for completion
  task automatic send(input logic [63:0] h, input logic [7:0] ep, input logic bc,
                      input logic [63:0] r, input int lim);
    int k;
    if (!bc)
      for (int i = 7; i >= 0; i--)
        rsp_q.push_back(r[i*8 +: 8]);
    wreg(FACH_REG_HDR0, h[63:32]);
    wreg(FACH_REG_HDR1, h[31:0]);
    wreg(FACH_REG_CTRL, {15'h0, bc, ep, 8'h01});
    wreg(FACH_REG_CTRL, {15'h0, bc, ep, 8'h01});
    idle(12);
    for (k = 0; k < lim && (busy !== 1'b0 || rsp_q.size() != 0); k++)
      idle(1);
    if (k >= lim)
    begin
      fails++;
      $display("ERROR %0t request did not complete", $time);
    end
    idle(20);
    `CHK(rsp_q.size(), 0, "replies missing")
    $display("test done, header %h", h);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // result watchers and timeout
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    rd_p <= rd;
    if (rd_p)
    begin
      e_w = rd_q.pop_front();
      e_m = rm_q.pop_front();
      `CHK(rdata & e_m, e_w, "register read")
    end
    if (link.rsp_valid === 1'b1)
    begin
      e_b = (rsp_q.size() == 0) ? ~link.rsp_byte : rsp_q.pop_front();
      `CHK(link.rsp_byte, e_b, "reply byte")
    end
    cyc_n++;
    if (cyc_n == 90000)
    begin
      fails++;
      $display("ERROR %0t run did not finish", $time);
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0]  ep;
    logic [15:0] b;
    logic [15:0] o;
    int          base;
    void'($urandom(32'h84c288bd));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    send(64'h0, 8'hE6, 1'b0, 64'h8000_0077_0200_0000, 200);
    `CHK(irq, 1'b0, "masked irq")
    rreg(FACH_REG_RESP0, 32'h8000_0077, 32'hFFFF_FFFF);
    rreg(FACH_REG_RESP1, 32'h0200_0000, 32'hFFFF_FFFF);
    rreg(FACH_REG_STATUS, 32'h0, 32'hFFFF_FFFF);
    rreg(FACH_REG_CTRL, 32'h0000_E602, 32'h0001_FF03);
    rreg(FACH_REG_IRQ, 32'h1, 32'h1);
    wreg(FACH_REG_MASK, 32'h3);
    idle(3);
    `CHK(irq, 1'b1, "unmasked irq")
    wreg(FACH_REG_IRQ, 32'h1);
    idle(3);
    `CHK(irq, 1'b0, "cleared irq")
    for (int i = 0; i < 2; i++)
    begin
      ep = 8'($urandom_range(229, 1));
      b = i ? 16'h0076 : 16'($urandom_range(118));
      o = 16'($urandom());
      send({16'h0100, b, o, 16'h0200}, ep, 1'b0,
           {16'h8100, b, o, 16'h0}, 900);
      base = int'(b) * FACH_BLOCK_BYTES;
      `CHK(fach_device_i.u_flash.mem[base], 8'hFF, "block start erased")
      `CHK(fach_device_i.u_flash.mem[base + FACH_BLOCK_BYTES - 1], 8'hFF, "block end erased")
      `CHK(fach_device_i.u_flash.mem[base + FACH_BLOCK_BYTES] === 8'hFF, 1'b0, "next kept")
      rreg(FACH_REG_CTRL, {16'h0, ep, 8'h00}, 32'h0001_FF03);
    end
    send(64'h0100_0077_0000_0200, 8'hE6, 1'b0, 64'h8101_0077_0000_0000, 200);
    rreg(FACH_REG_IRQ, 32'h2, 32'h2);
    wreg(FACH_REG_IRQ, 32'h3);
    send(64'h0500_0000_0000_0000, 8'hE6, 1'b0, 64'h8501_0000_0000_0000, 200);
    send(64'h0100_0005_0000_0200, 8'hE6, 1'b1, 64'h0, 900);
    `CHK(fach_device_i.u_flash.mem[5 * FACH_BLOCK_BYTES], 8'hFF, "broadcast erase")
    fork
      begin
        repeat (5000) @(posedge clk);
        `CHK(erasing, 1'b1, "erase sweep running")
      end
    join_none
    send(64'h0100_00FF_0000_0000, 8'h42, 1'b0, 64'h8100_00FF_0000_0000, 62000);
    `CHK(erasing, 1'b0, "erase sweep ended")
    `CHK(fach_device_i.u_flash.mem[0], 8'hFF, "first byte erased")
    `CHK(fach_device_i.u_flash.mem[FACH_MEM_BYTES - 1], 8'hFF, "last byte erased")
    report_and_stop();
  end
endmodule // tb_flash_area_command_handler
`default_nettype wire
